// >>> logic/motd_core.v
// Magnetometer user offsets and magnetic threshold event detector.
// Assumes samples, strobes and register accesses all come from logic
// on clk; one sample_valid pulse marks each new magnetic sample.
//
// Function
// - High offset register holds bits 14..7
// - Low register bits 7..1 hold bits 6..0
// - Thresholds are unsigned 15-bit per axis
// - Select 0: all enabled axes at/below
// - Select 1: any enabled axis at/above
// - Flag sets after debounce count is met
// - Axis enable bits include or exclude axes
// - Latched flag clears on source register read
// - Unlatched flag follows live detection result
// - Wake enable gates flag into sleep logic
// - Interrupt enable routes flag to chosen pin
// - Offset subtracted from output when not raw
// - Thresholds compare against uncorrected samples
// - Lapse clears or decrements debounce counter
`timescale 1ns/1ns
`include "motd_map.vh"

module motd_core #(
  parameter SAMPLE_W = 16,
  parameter CNT_W    = 8
)(
  input  wire                  clk,
  input  wire                  rst_n,
  // Register port
  input  wire [7:0]            reg_addr,
  input  wire                  reg_wr,
  input  wire [7:0]            reg_wdata,
  input  wire                  reg_rd,
  output reg  [7:0]            reg_rdata,
  // Magnetic samples, x in low lane, z in high lane
  input  wire                  sample_valid,
  input  wire [3*SAMPLE_W-1:0] raw_sample,
  input  wire                  raw_mode,
  // Threshold settings held elsewhere
  input  wire [44:0]           threshold_xyz,
  input  wire [CNT_W-1:0]      debounce_count_setting,
  input  wire                  debounce_clear_mode,
  // Other interrupt sources sharing the pins
  input  wire                  irq_one_other,
  input  wire                  irq_two_other,
  // Results
  output reg  [3*SAMPLE_W-1:0] mag_out,
  output reg                   mag_out_valid,
  output wire                  threshold_event,
  output wire                  wake_event,
  output wire                  irq_pin_one,
  output wire                  irq_pin_two
);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  reg  [7:0]       off_high_reg [0:2];
  reg  [7:0]       off_low_reg  [0:2];
  reg  [7:0]       cfg_reg;
  reg  [CNT_W-1:0] dbc_reg;
  reg              flag_reg;
  reg  [5:0]       axis_src_reg;

  wire [2:0]       axis_en;
  wire [2:0]       at_or_below;
  wire [2:0]       at_or_above;
  wire [5:0]       axis_src_live;
  wire             src_read;

  // Corrected samples of all three axes, gathered for one output register
  wire [3*SAMPLE_W-1:0] corrected_all;

  // Unit steps sized to their targets, so no sum or difference widens
  localparam [CNT_W-1:0]    CNT_ONE    = {{(CNT_W-1){1'b0}}, 1'b1};
  localparam [SAMPLE_W-1:0] SAMPLE_ONE = {{(SAMPLE_W-1){1'b0}}, 1'b1};

  // Enable bits ordered x, y, z
  assign axis_en = {cfg_reg[`MOTD_CFG_EN_Z], cfg_reg[`MOTD_CFG_EN_Y],
                    cfg_reg[`MOTD_CFG_EN_X]};

  // Reading the source register is what releases a latched event
  assign src_read = reg_rd && (reg_addr == `MOTD_ADDR_THS_SRC);

  // ****************************************************************
  // Per-axis offset correction and threshold compare
  // ****************************************************************
  genvar ax;
  generate
    for (ax = 0; ax < 3; ax = ax + 1)
    begin : g_axis
      wire [SAMPLE_W-1:0] raw;
      wire [14:0]         offset;
      wire [SAMPLE_W-1:0] offset_ext;
      wire [SAMPLE_W-1:0] corrected;
      wire [SAMPLE_W-1:0] magnitude;
      wire [SAMPLE_W-1:0] limit;

      assign raw    = raw_sample[ax*SAMPLE_W +: SAMPLE_W];
      // Offset reassembled from the two eight-bit halves
      assign offset = {off_high_reg[ax], off_low_reg[ax][7:1]};
      assign offset_ext = {{(SAMPLE_W-15){offset[14]}}, offset};
      // Raw mode bypasses the user offset entirely
      assign corrected = raw_mode ? raw : (raw - offset_ext);
      // Compare magnitude; a full-scale negative reading stays 0x8000,
      // which is above any 15-bit threshold as it should be
      assign magnitude = raw[SAMPLE_W-1] ? (~raw + SAMPLE_ONE) : raw;
      assign limit = {{(SAMPLE_W-15){1'b0}}, threshold_xyz[ax*15 +: 15]};
      // Disabled axes never block the AND nor fire the OR
      assign at_or_below[ax] = !axis_en[ax] || (magnitude <= limit);
      assign at_or_above[ax] = axis_en[ax] && (magnitude >= limit);
      // Source detail: high event and its polarity
      assign axis_src_live[2*ax+1] = at_or_above[ax];
      assign axis_src_live[2*ax]   = at_or_above[ax] && raw[SAMPLE_W-1];

      assign corrected_all[ax*SAMPLE_W +: SAMPLE_W] = corrected;
    end
  endgenerate

  // Corrected data goes out once per sample; one process owns all
  // three lanes so the output register has a single driver
  always @(posedge clk)
  begin
    if (!rst_n)
      mag_out <= {(3*SAMPLE_W){1'b0}};
    else if (sample_valid)
      mag_out <= corrected_all;
  end

  // ****************************************************************
  // Axis combination and debounce
  // ****************************************************************
  wire             any_enabled;
  wire             condition;
  reg  [CNT_W-1:0] dbc_next;
  reg              detect;

  // Thresholds, count and counter mode arrive as inputs; their
  // registers sit outside this block and must be stable per sample
  assign any_enabled = |axis_en;
  // With no axis enabled nothing can be detected
  assign condition = any_enabled &&
                     (cfg_reg[`MOTD_CFG_OR_ABOVE] ? (|at_or_above)
                                                  : (&at_or_below));

  // Counter saturates at the setting; event once the setting is met.
  // Saturating keeps a long event from wrapping the count, so one
  // lapse in decrement mode only steps back one sample from firing
  always @*
  begin
    dbc_next = dbc_reg;
    detect   = 1'b0;
    if (condition)
    begin
      if (dbc_reg < debounce_count_setting)
        dbc_next = dbc_reg + CNT_ONE;
      detect = (dbc_next >= debounce_count_setting);
    end
    else if (debounce_clear_mode)
      dbc_next = {CNT_W{1'b0}};
    else if (dbc_reg != {CNT_W{1'b0}})
      dbc_next = dbc_reg - CNT_ONE;
  end

  // Debounce advances only on a new sample
  always @(posedge clk)
  begin
    if (!rst_n)
      dbc_reg <= `MOTD_RST_CNT;
    else if (sample_valid)
      dbc_reg <= dbc_next;
  end

  // ****************************************************************
  // Event flag and source detail
  // ****************************************************************
  // A detection in the same cycle as a clearing read wins, so no
  // event is lost between the host's read and the next sample
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      flag_reg     <= 1'b0;
      axis_src_reg <= 6'h00;
    end
    else if (cfg_reg[`MOTD_CFG_LATCH])
    begin
      if (sample_valid && detect)
      begin
        flag_reg     <= 1'b1;
        axis_src_reg <= axis_src_reg | axis_src_live;
      end
      else if (src_read)
      begin
        flag_reg     <= 1'b0;
        axis_src_reg <= 6'h00;
      end
    end
    else if (sample_valid)
    begin
      flag_reg     <= detect;
      axis_src_reg <= detect ? axis_src_live : 6'h00;
    end
  end

  // ****************************************************************
  // Outputs to wake logic and interrupt pins
  // ****************************************************************
  wire irq_gated;

  // Pins are combinational and active high; other sources pass
  // straight through, so this block never delays their interrupts
  assign threshold_event = flag_reg;
  assign wake_event = flag_reg && cfg_reg[`MOTD_CFG_WAKE_EN];
  assign irq_gated  = flag_reg && cfg_reg[`MOTD_CFG_INT_EN];
  assign irq_pin_one = irq_one_other ||
                       (irq_gated && cfg_reg[`MOTD_CFG_ROUTE_ONE]);
  assign irq_pin_two = irq_two_other ||
                       (irq_gated && !cfg_reg[`MOTD_CFG_ROUTE_ONE]);

  // Sample strobe delayed to line up with the output data
  always @(posedge clk)
  begin
    if (!rst_n)
      mag_out_valid <= 1'b0;
    else
      mag_out_valid <= sample_valid;
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************
  integer i;

  // Low offset bit 0 is unused and always stored as zero; writes to
  // the read-only source address or unmapped addresses change nothing
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      for (i = 0; i < 3; i = i + 1)
      begin
        off_high_reg[i] <= `MOTD_RST_OFF;
        off_low_reg[i]  <= `MOTD_RST_OFF;
      end
      cfg_reg <= `MOTD_RST_CFG;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `MOTD_ADDR_OFF_X_HIGH : off_high_reg[0] <= reg_wdata;
        `MOTD_ADDR_OFF_X_LOW  : off_low_reg[0]  <= {reg_wdata[7:1], 1'b0};
        `MOTD_ADDR_OFF_Y_HIGH : off_high_reg[1] <= reg_wdata;
        `MOTD_ADDR_OFF_Y_LOW  : off_low_reg[1]  <= {reg_wdata[7:1], 1'b0};
        `MOTD_ADDR_OFF_Z_HIGH : off_high_reg[2] <= reg_wdata;
        `MOTD_ADDR_OFF_Z_LOW  : off_low_reg[2]  <= {reg_wdata[7:1], 1'b0};
        `MOTD_ADDR_THS_CFG    : cfg_reg         <= reg_wdata;
        default               : cfg_reg         <= cfg_reg;
      endcase
    end
  end

  // ****************************************************************
  // Register reads
  // ****************************************************************
  reg [7:0] rdata_next;
  reg [7:0] src_word;

  // Source word: event flag on top, bit 6 always reads as zero,
  // axis event and polarity pairs below
  always @*
  begin
    src_word                       = 8'h00;
    src_word[`MOTD_SRC_ACTIVE]     = flag_reg;
    src_word[`MOTD_SRC_X_POL +: 6] = axis_src_reg;
  end

  // Unmapped addresses read as zero; reading has no side effect
  // except at the source address, where it releases a latched flag
  always @*
  begin
    case (reg_addr)
      `MOTD_ADDR_OFF_X_HIGH : rdata_next = off_high_reg[0];
      `MOTD_ADDR_OFF_X_LOW  : rdata_next = off_low_reg[0];
      `MOTD_ADDR_OFF_Y_HIGH : rdata_next = off_high_reg[1];
      `MOTD_ADDR_OFF_Y_LOW  : rdata_next = off_low_reg[1];
      `MOTD_ADDR_OFF_Z_HIGH : rdata_next = off_high_reg[2];
      `MOTD_ADDR_OFF_Z_LOW  : rdata_next = off_low_reg[2];
      `MOTD_ADDR_THS_CFG    : rdata_next = cfg_reg;
      `MOTD_ADDR_THS_SRC    : rdata_next = src_word;
      default               : rdata_next = 8'h00;
    endcase
  end

  // Read data held until the next read strobe
  always @(posedge clk)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rdata_next;
  end

endmodule // motd_core

// >>> shared/motd_map.vh
// Register map, field positions and reset values of the magnetic
// offset and threshold detector.
// Assumes 8-bit register addresses and 8-bit register data.
`ifndef MOTD_MAP_VH
`define MOTD_MAP_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define MOTD_ADDR_OFF_X_HIGH   8'h3F
`define MOTD_ADDR_OFF_X_LOW    8'h40
`define MOTD_ADDR_OFF_Y_HIGH   8'h41
`define MOTD_ADDR_OFF_Y_LOW    8'h42
`define MOTD_ADDR_OFF_Z_HIGH   8'h43
`define MOTD_ADDR_OFF_Z_LOW    8'h44
`define MOTD_ADDR_THS_CFG      8'h52
`define MOTD_ADDR_THS_SRC      8'h53

// ****************************************************************
// Reset values
// ****************************************************************
`define MOTD_RST_OFF           8'h00
`define MOTD_RST_CFG           8'h00
`define MOTD_RST_CNT           8'h00

// ****************************************************************
// Threshold configuration fields
// ****************************************************************
`define MOTD_CFG_LATCH         7
`define MOTD_CFG_OR_ABOVE      6
`define MOTD_CFG_EN_Z          5
`define MOTD_CFG_EN_Y          4
`define MOTD_CFG_EN_X          3
`define MOTD_CFG_WAKE_EN       2
`define MOTD_CFG_INT_EN        1
`define MOTD_CFG_ROUTE_ONE     0

// ****************************************************************
// Event source fields
// ****************************************************************
`define MOTD_SRC_ACTIVE        7
`define MOTD_SRC_X_POL         0

`endif

// >>> test/motd_host.sv
// Host model: register writes and reads on the register port.
// Assumes the bench calls wr and rd; strobes move on falling edges.
`timescale 1ns/1ns
module motd_host (
  input  wire       clk,
  output reg  [7:0] reg_addr,
  output reg        reg_wr,
  output reg  [7:0] reg_wdata,
  output reg        reg_rd,
  input  wire [7:0] reg_rdata
);
  // Idle data is inverted so a stale value is never taken
  initial {reg_addr, reg_wr, reg_wdata, reg_rd} = 18'h00000;
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge clk) {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
      @(negedge clk) {reg_wdata, reg_wr} = {~d, 1'b0};
    end
  endtask
  // Data is taken a full cycle after the strobe falls, two cycles after it rises
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(negedge clk) {reg_addr, reg_rd} = {a, 1'b1};
      @(negedge clk) reg_rd = 1'b0;
      @(negedge clk) d = reg_rdata;
    end
  endtask
endmodule // motd_host

// >>> test/motd_chk.sv
// Checker: port timing of motd_core.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module motd_chk #(
  parameter SAMPLE_W = 16,
  parameter CNT_W    = 8
)(
  input wire                  clk,
  input wire                  rst_n,
  input wire [7:0]            reg_addr,
  input wire                  reg_rd,
  input wire [7:0]            reg_rdata,
  input wire                  sample_valid,
  input wire [3*SAMPLE_W-1:0] raw_sample,
  input wire                  raw_mode,
  input wire                  irq_one_other,
  input wire                  irq_two_other,
  input wire [3*SAMPLE_W-1:0] mag_out,
  input wire                  mag_out_valid,
  input wire                  threshold_event,
  input wire                  wake_event,
  input wire                  irq_pin_one,
  input wire                  irq_pin_two
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Reset check must run while reset is low
  a_reset_clear: assert property (@(posedge clk) disable iff (1'b0) !rst_n |=>
    (reg_rdata == 8'h00) && !threshold_event && !mag_out_valid) else $error("not cleared");
  a_wake_flag: assert property (wake_event |-> threshold_event)
    else $error("wake without flag");
  a_irq_quiet: assert property (!threshold_event |->
    irq_pin_one == irq_one_other && irq_pin_two == irq_two_other) else $error("pin level");
  a_out_pulse: assert property (mag_out_valid == $past(sample_valid))
    else $error("valid pulse");
  a_raw_pass: assert property (sample_valid && raw_mode |=> mag_out == $past(raw_sample))
    else $error("raw output");
  a_mag_hold: assert property (!sample_valid |=> $stable(mag_out))
    else $error("output moved");
  // Flag may move only on a sample or a source read
  a_flag_hold: assert property (!sample_valid && !(reg_rd && reg_addr == 8'h53)
    |=> $stable(threshold_event)) else $error("flag moved");
  a_rise_cause: assert property ($rose(threshold_event) |-> $past(sample_valid))
    else $error("flag without sample");
  a_rd_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
endmodule // motd_chk
bind motd_core motd_chk #(.SAMPLE_W(SAMPLE_W), .CNT_W(CNT_W)) chk_u (.clk, .rst_n, .reg_addr,
  .reg_rd, .reg_rdata, .sample_valid, .raw_sample, .raw_mode, .irq_one_other, .irq_two_other,
  .mag_out, .mag_out_valid, .threshold_event, .wake_event, .irq_pin_one, .irq_pin_two);

// >>> test/mag_offset_threshold_detect_bench.sv
// Bench for motd_core: registers, detect modes, debounce, latch, pins.
// Assumes motd_host drives the register port; 20 MHz clock.
`timescale 1ns/1ns
`include "motd_map.vh"
module mag_offset_threshold_detect_bench;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         sample_valid = 1'b0;
  reg  [47:0] raw_sample = 48'h0;
  reg         raw_mode = 1'b0;
  reg  [44:0] threshold_xyz = {3{15'h0064}};
  reg  [7:0]  debounce_count_setting = 8'h01;
  reg         debounce_clear_mode = 1'b1;
  reg         irq_one_other = 1'b0;
  reg         irq_two_other = 1'b0;
  wire [7:0]  reg_addr, reg_wdata, reg_rdata;
  wire        reg_wr, reg_rd, mag_out_valid, threshold_event;
  wire        wake_event, irq_pin_one, irq_pin_two;
  wire [47:0] mag_out;
  reg  [56:0] rows [0:8];
  reg  [7:0]  d;
  integer     n_mismatch = 0;
  integer     checked = 0;
  integer     i;
  // 50 ns period
  always #25 clk = ~clk;
  motd_host host_u (.clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata);
  motd_core dut_u (.clk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .sample_valid, .raw_sample, .raw_mode, .threshold_xyz, .debounce_count_setting,
    .debounce_clear_mode, .irq_one_other, .irq_two_other, .mag_out, .mag_out_valid,
    .threshold_event, .wake_event, .irq_pin_one, .irq_pin_two);
  task chk(input string what, input [47:0] seen, input [47:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp)
      begin
        n_mismatch = n_mismatch + 1;
        $display("Error %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  // Output valid is read half a cycle after the taking edge, then again a cycle later
  task samp(input [47:0] s);
    begin
      @(negedge clk) {raw_sample, sample_valid} = {s, 1'b1};
      @(negedge clk) sample_valid = 1'b0;
      chk("out valid", mag_out_valid, 1'b1);
      @(negedge clk);
      chk("valid pulse", mag_out_valid, 1'b0);
    end
  endtask
  task seq(input [7:0] hit, input [7:0] exp, input integer n);
    integer k;
    begin
      for (k = 0; k < n; k = k + 1)
      begin
        samp(hit[k] ? 48'h0064 : 48'h0010);
        chk("debounce", threshold_event, exp[k]);
      end
    end
  endtask
  task results;
    begin
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // Hang guard
  initial
  begin
    repeat (5000) @(posedge clk);
    n_mismatch = n_mismatch + 1;
    results;
  end
  // Rows: config, {z, y, x} sample, expected flag; thresholds all 0x64
  initial
  begin
    rows[0] = {8'h08, 48'h0000_0000_0064, 1'b1};
    rows[1] = {8'h08, 48'h0000_0000_0065, 1'b0};
    rows[2] = {8'h18, 48'h0000_0065_0010, 1'b0};
    rows[3] = {8'h48, 48'h0000_0000_0064, 1'b1};
    rows[4] = {8'h48, 48'h0000_0000_0063, 1'b0};
    rows[5] = {8'h50, 48'h0000_0010_0FFF, 1'b0};
    rows[6] = {8'h60, 48'hFF9C_0000_0000, 1'b1};
    rows[7] = {8'h40, 48'h0000_0000_7FFF, 1'b0};
    rows[8] = {8'h00, 48'h0000_0000_0000, 1'b0};
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    for (i = 0; i < 8; i = i + 1)
    begin
      host_u.rd((i < 6) ? 8'h3F + i[7:0] : ((i == 6) ? 8'h52 : 8'h60), d);
      chk("reset reg", d, 8'h00);
    end
    for (i = 0; i < 9; i = i + 1)
    begin
      host_u.wr(`MOTD_ADDR_THS_CFG, rows[i][56:49]);
      samp(rows[i][48:1]);
      chk("row event", threshold_event, rows[i][0]);
    end
    // Decrement mode then clear mode, count of three
    host_u.wr(`MOTD_ADDR_THS_CFG, 8'h48);
    debounce_count_setting = 8'h03;
    seq(8'h00, 8'h00, 1);
    debounce_clear_mode = 1'b0;
    seq(8'h1B, 8'h10, 5);
    debounce_clear_mode = 1'b1;
    seq(8'h76, 8'h40, 7);
    // Offsets: x = 129, y = -1; compare must use the raw value
    host_u.wr(`MOTD_ADDR_OFF_X_HIGH, 8'h01);
    host_u.wr(`MOTD_ADDR_OFF_X_LOW, 8'h03);
    host_u.wr(`MOTD_ADDR_OFF_Y_HIGH, 8'hFF);
    host_u.wr(`MOTD_ADDR_OFF_Y_LOW, 8'hFE);
    host_u.rd(`MOTD_ADDR_OFF_X_LOW, d);
    chk("low reg", d, 8'h02);
    host_u.rd(`MOTD_ADDR_OFF_Y_HIGH, d);
    chk("high reg", d, 8'hFF);
    threshold_xyz[14:0] = 15'h03E8;
    debounce_count_setting = 8'h01;
    samp({16'h0007, 16'h0005, 16'h03E8});
    chk("corrected", mag_out, {16'h0007, 16'h0006, 16'h0367});
    chk("raw compare", threshold_event, 1'b1);
    raw_mode = 1'b1;
    samp({16'h0007, 16'h0005, 16'h03E8});
    chk("raw out", mag_out, {16'h0007, 16'h0005, 16'h03E8});
    // Latched flag, wake and pin routing
    host_u.wr(`MOTD_ADDR_THS_CFG, 8'hCE);
    host_u.rd(`MOTD_ADDR_THS_CFG, d);
    chk("config", d, 8'hCE);
    samp(48'h03E8);
    chk("pins two", {irq_pin_two, irq_pin_one, wake_event}, 3'b101);
    samp(48'h0010);
    chk("latched", threshold_event, 1'b1);
    host_u.rd(`MOTD_ADDR_THS_SRC, d);
    chk("source", d[7], 1'b1);
    chk("cleared", threshold_event, 1'b0);
    host_u.wr(`MOTD_ADDR_THS_CFG, 8'hCB);
    irq_two_other = 1'b1;
    samp(48'h03E8);
    chk("pins one", {irq_pin_two, irq_pin_one, wake_event}, 3'b110);
    // Second reset in mid-run clears flag and registers
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk("reset flag", {threshold_event, irq_pin_one}, 2'b00);
    host_u.rd(`MOTD_ADDR_OFF_X_HIGH, d);
    chk("reset off", d, 8'h00);
    results;
  end
endmodule // mag_offset_threshold_detect_bench
